// >>> core/lait_device.sv
`timescale 1ns/1ns
module lait_device
    import lait_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    lait_if.dev             bus,
    input  wire logic [15:0] light_count_in,
    output logic            conv_tick_out,
    output logic            array_sel_out,
    output logic            integrating_out,
    output logic            result_pulse_out
);
    typedef enum logic [1:0] {
        LAIT_ST_IDLE,
        LAIT_ST_ARRAY1,
        LAIT_ST_ARRAY2
    } lait_state_t;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  command_q, command_d;
    logic [7:0]  control_q, control_d;
    logic [15:0] data_q, data_d;
    logic [15:0] timer_q, timer_d;
    logic [3:0]  div_q, div_d;
    logic [16:0] cyc_q, cyc_d;
    logic        fast_q, fast_d;
    lait_state_t state_q, state_d;
    logic        rsp_valid_q, rsp_valid_d;
    logic [7:0]  rsp_rdata_q, rsp_rdata_d;
    logic        result_q, result_d;

    logic        ext_mode;
    logic        tick;
    logic        sync_cmd;
    logic [16:0] target;
    logic [3:0]  div_end;

    assign ext_mode = command_q[LAIT_BIT_EXT_MODE];
    assign sync_cmd = bus.req_valid && bus.req_kind == LAIT_REQ_SYNC;
    // Rate latched per integration so a range write never cuts a period short
    assign div_end  = fast_q ? 4'(LAIT_FAST_DIV - 1) : 4'(LAIT_SLOW_DIV - 1);
    assign tick     = (div_q == div_end);

    always_comb begin
        case (command_q[LAIT_BIT_WIDTH_LO +: 2])
            2'b00:   target = LAIT_CYC_W0;
            2'b01:   target = LAIT_CYC_W1;
            2'b10:   target = LAIT_CYC_W2;
            default: target = LAIT_CYC_W3;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        command_d   = command_q;
        control_d   = control_q;
        data_d      = data_q;
        timer_d     = timer_q;
        state_d     = state_q;
        fast_d      = fast_q;
        result_d    = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_rdata_d = rsp_rdata_q;
        div_d       = tick ? 4'h0 : div_q + 4'h1;
        cyc_d       = cyc_q;
        if (bus.req_valid && bus.req_kind == LAIT_REQ_WRITE) begin
            if (bus.req_addr == LAIT_OFS_COMMAND) begin
                command_d = bus.req_wdata;
            end else if (bus.req_addr == LAIT_OFS_CONTROL) begin
                control_d = bus.req_wdata;
            end
        end
        if (bus.req_valid && bus.req_kind == LAIT_REQ_READ) begin
            rsp_valid_d = 1'b1;
            case (bus.req_addr)
                LAIT_OFS_COMMAND:   rsp_rdata_d = command_q;
                LAIT_OFS_CONTROL:   rsp_rdata_d = control_q;
                LAIT_OFS_DATA_LSB:  rsp_rdata_d = data_q[7:0];
                LAIT_OFS_DATA_MSB:  rsp_rdata_d = data_q[15:8];
                LAIT_OFS_TIMER_LSB: rsp_rdata_d = timer_q[7:0];
                LAIT_OFS_TIMER_MSB: rsp_rdata_d = timer_q[15:8];
                default:            rsp_rdata_d = 8'h00;
            endcase
        end
        if (!ext_mode) begin
            // Internal timing: fixed count, free running
            if (state_q == LAIT_ST_IDLE) begin
                state_d = LAIT_ST_ARRAY1;
                cyc_d   = 17'h0;
                fast_d  = control_q[LAIT_BIT_RANGE_LO + 1];
                div_d   = 4'h0;
            end else if (tick) begin
                // Greater-or-equal so a shorter width written mid-period ends it instead of wrapping the count
                if (cyc_q + 17'h1 >= target) begin
                    data_d   = light_count_in;
                    result_d = 1'b1;
                    cyc_d    = 17'h0;
                    fast_d   = control_q[LAIT_BIT_RANGE_LO + 1];
                    state_d  = LAIT_ST_ARRAY1;
                end else begin
                    cyc_d = cyc_q + 17'h1;
                    // Second half of the period converts the second array
                    state_d = (cyc_q + 17'h1 >= (target >> 1)) ? LAIT_ST_ARRAY2 : LAIT_ST_ARRAY1;
                end
            end
        end else begin
            // External timing: syncs frame the period, cycles are counted
            if (tick && state_q != LAIT_ST_IDLE && cyc_q[15:0] != LAIT_CNT_MAX) begin
                cyc_d = cyc_q + 17'h1;
            end
            if (sync_cmd) begin
                case (state_q)
                    LAIT_ST_IDLE: begin
                        state_d = LAIT_ST_ARRAY1;
                        cyc_d   = 17'h0;
                        fast_d  = control_q[LAIT_BIT_RANGE_LO + 1];
                        div_d   = 4'h0;
                    end
                    LAIT_ST_ARRAY1: state_d = LAIT_ST_ARRAY2;
                    LAIT_ST_ARRAY2: begin
                        data_d   = light_count_in;
                        timer_d  = cyc_q[15:0];
                        result_d = 1'b1;
                        state_d  = LAIT_ST_ARRAY1;
                        cyc_d    = 17'h0;
                        fast_d   = control_q[LAIT_BIT_RANGE_LO + 1];
                        div_d    = 4'h0;
                    end
                    default: state_d = LAIT_ST_IDLE;
                endcase
            end
        end
        // Mode switch abandons any period in flight
        if (bus.req_valid && bus.req_kind == LAIT_REQ_WRITE && bus.req_addr == LAIT_OFS_COMMAND
            && bus.req_wdata[LAIT_BIT_EXT_MODE] != ext_mode) begin
            state_d = LAIT_ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            command_q   <= LAIT_RST_COMMAND;
            control_q   <= LAIT_RST_CONTROL;
            data_q      <= 16'h0000;
            timer_q     <= 16'h0000;
            div_q       <= 4'h0;
            cyc_q       <= 17'h0;
            fast_q      <= 1'b0;
            state_q     <= LAIT_ST_IDLE;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
            result_q    <= 1'b0;
        end else begin
            command_q   <= command_d;
            control_q   <= control_d;
            data_q      <= data_d;
            timer_q     <= timer_d;
            div_q       <= div_d;
            cyc_q       <= cyc_d;
            fast_q      <= fast_d;
            state_q     <= state_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_rdata_q <= rsp_rdata_d;
            result_q    <= result_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign bus.rsp_valid    = rsp_valid_q;
    assign bus.rsp_rdata    = rsp_rdata_q;
    assign conv_tick_out    = tick && state_q != LAIT_ST_IDLE;
    assign array_sel_out    = state_q == LAIT_ST_ARRAY2;
    assign integrating_out  = state_q != LAIT_ST_IDLE;
    assign result_pulse_out = result_q;
endmodule

// >>> core/lait_pkg.sv
package lait_pkg;
    // Register offsets
    localparam logic [7:0] LAIT_OFS_COMMAND   = 8'h00;
    localparam logic [7:0] LAIT_OFS_CONTROL   = 8'h01;
    localparam logic [7:0] LAIT_OFS_DATA_LSB  = 8'h04;
    localparam logic [7:0] LAIT_OFS_DATA_MSB  = 8'h05;
    localparam logic [7:0] LAIT_OFS_TIMER_LSB = 8'h06;
    localparam logic [7:0] LAIT_OFS_TIMER_MSB = 8'h07;
    // Field positions
    localparam int LAIT_BIT_EXT_MODE = 5;
    localparam int LAIT_BIT_WIDTH_LO = 0;
    localparam int LAIT_BIT_RANGE_LO = 2;
    // Reset values
    localparam logic [7:0] LAIT_RST_COMMAND = 8'h00;
    localparam logic [7:0] LAIT_RST_CONTROL = 8'h00;
    // Conversion clock: full rate tick every FAST_DIV system cycles, half rate doubles it
    localparam int LAIT_FAST_DIV = 4;
    localparam int LAIT_SLOW_DIV = 2 * LAIT_FAST_DIV;
    // Cycles per integration for width codes 00..11
    localparam logic [16:0] LAIT_CYC_W0 = 17'h10000;
    localparam logic [16:0] LAIT_CYC_W1 = 17'h01000;
    localparam logic [16:0] LAIT_CYC_W2 = 17'h00100;
    localparam logic [16:0] LAIT_CYC_W3 = 17'h00010;
    localparam logic [15:0] LAIT_CNT_MAX = 16'hffff;

    typedef enum logic [1:0] {
        LAIT_REQ_WRITE,
        LAIT_REQ_READ,
        LAIT_REQ_SYNC
    } lait_req_t;
endpackage

// >>> core/lait_if.sv
`timescale 1ns/1ns
interface lait_if;
    logic            req_valid;
    lait_pkg::lait_req_t req_kind;
    logic [7:0]      req_addr;
    logic [7:0]      req_wdata;
    logic            rsp_valid;
    logic [7:0]      rsp_rdata;

    modport dev  (input req_valid, req_kind, req_addr, req_wdata, output rsp_valid, rsp_rdata);
    modport host (output req_valid, req_kind, req_addr, req_wdata, input rsp_valid, rsp_rdata);
endinterface

// >>> core/lait_host.sv
`timescale 1ns/1ns
module lait_host
    import lait_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    lait_if.host            bus,
    input  wire logic       cmd_valid_in,
    input  wire lait_req_t  cmd_kind_in,
    input  wire logic [7:0] cmd_addr_in,
    input  wire logic [7:0] cmd_wdata_in,
    output logic            cmd_ready_out,
    output logic            rd_valid_out,
    output logic [7:0]      rd_data_out
);
    logic            req_valid_q, req_valid_d;
    lait_req_t       req_kind_q, req_kind_d;
    logic [7:0]      req_addr_q, req_addr_d;
    logic [7:0]      req_wdata_q, req_wdata_d;
    logic            busy_q, busy_d;
    logic            rd_valid_q, rd_valid_d;
    logic [7:0]      rd_data_q, rd_data_d;

    // One request in flight; a read holds the port until its answer returns
    assign cmd_ready_out = !busy_q && !req_valid_q;

    always_comb begin
        req_valid_d = 1'b0;
        req_kind_d  = req_kind_q;
        req_addr_d  = req_addr_q;
        req_wdata_d = req_wdata_q;
        busy_d      = busy_q;
        rd_valid_d  = 1'b0;
        rd_data_d   = rd_data_q;
        // Sync spacing and count limit are timed by the user side
        if (cmd_valid_in && cmd_ready_out) begin
            req_valid_d = 1'b1;
            req_kind_d  = cmd_kind_in;
            req_addr_d  = cmd_addr_in;
            req_wdata_d = cmd_wdata_in;
            busy_d      = cmd_kind_in == LAIT_REQ_READ;
        end
        if (bus.rsp_valid) begin
            rd_valid_d = 1'b1;
            rd_data_d  = bus.rsp_rdata;
            busy_d     = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            req_valid_q <= 1'b0;
            req_kind_q  <= LAIT_REQ_WRITE;
            req_addr_q  <= 8'h00;
            req_wdata_q <= 8'h00;
            busy_q      <= 1'b0;
            rd_valid_q  <= 1'b0;
            rd_data_q   <= 8'h00;
        end else begin
            req_valid_q <= req_valid_d;
            req_kind_q  <= req_kind_d;
            req_addr_q  <= req_addr_d;
            req_wdata_q <= req_wdata_d;
            busy_q      <= busy_d;
            rd_valid_q  <= rd_valid_d;
            rd_data_q   <= rd_data_d;
        end
    end

    assign bus.req_valid = req_valid_q;
    assign bus.req_kind  = req_kind_q;
    assign bus.req_addr  = req_addr_q;
    assign bus.req_wdata = req_wdata_q;
    assign rd_valid_out  = rd_valid_q;
    assign rd_data_out   = rd_data_q;
endmodule

// >>> bench/lait_checker.sv
`timescale 1ns/1ns
module lait_checker
    import lait_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    input  wire logic       req_valid,
    input  wire lait_req_t  req_kind,
    input  wire logic [7:0] req_addr,
    input  wire logic [7:0] req_wdata,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_rdata,
    input  wire logic       conv_tick_out,
    input  wire logic       integrating_out,
    input  wire logic       result_pulse_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    logic       ext_q;
    logic [3:0] gap_q;
    wire        is_rd = req_valid && req_kind == LAIT_REQ_READ;
    ////////////////////////////////////////
    // Mode shadow and cycles since last tick, saturating so it never wraps back to a legal value
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ext_q <= 1'b0;
            gap_q <= 4'h0;
        end else begin
            if (req_valid && req_kind == LAIT_REQ_WRITE && req_addr == LAIT_OFS_COMMAND) begin
                ext_q <= req_wdata[LAIT_BIT_EXT_MODE];
            end
            // A sync from idle or the second array re-phases the divider, so the gap restarts on every sync
            gap_q <= (!integrating_out || conv_tick_out || (req_valid && req_kind == LAIT_REQ_SYNC)) ? 4'h0
                     : (gap_q == 4'hf ? gap_q : gap_q + 4'h1);
        end
    end
    ////////////////////////////////////////
    rd_answer_a: assert property (is_rd |=> rsp_valid) else $error("read not answered");
    rsp_cause_a: assert property (rsp_valid |-> $past(is_rd)) else $error("answer without read");
    rdata_hold_a: assert property (!rsp_valid |-> $stable(rsp_rdata)) else $error("read data moved");
    tick_gate_a: assert property (conv_tick_out |-> integrating_out) else $error("tick while idle");
    tick_space_a: assert property (conv_tick_out |=> !conv_tick_out [*3]) else $error("ticks too close");
    tick_gap_a: assert property (gap_q < 4'hc) else $error("tick gap too long");
    res_pulse_a: assert property (result_pulse_out |=> !result_pulse_out) else $error("result pulse long");
    res_cause_a: assert property (!ext_q && result_pulse_out |-> $past(conv_tick_out) || $past(conv_tick_out, 2))
        else $error("result without tick");
    run_on_a: assert property (!ext_q && !req_valid && !$past(req_valid) && integrating_out |=> integrating_out)
        else $error("internal run stopped");
    cover property (result_pulse_out && !ext_q);
    cover property (result_pulse_out && ext_q);
    cover property (is_rd ##1 rsp_valid);
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb
    import lait_pkg::*;
;
    logic        clk_sys_in     = 1'b0;
    logic        sys_rst_in     = 1'b1;
    logic        cmd_valid_in   = 1'b0;
    lait_req_t   cmd_kind_in    = LAIT_REQ_WRITE;
    logic [7:0]  cmd_addr_in    = 8'h00;
    logic [7:0]  cmd_wdata_in   = 8'h00;
    logic [15:0] light_count_in = 16'h0000;
    logic        cmd_ready_out, rd_valid_out, conv_tick_out, array_sel_out, integrating_out, result_pulse_out;
    logic [7:0]  rd_data_out;
    int          n_mismatch = 0, num_checks = 0, cyc = 0, n_res = 0, per_cyc = 0, per_tick = 0, cyc_cnt = 0, tick_cnt = 0;
    int          lc_q [$];
    lait_if bus_if ();
    lait_host lait_host_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .bus(bus_if), .cmd_valid_in(cmd_valid_in),
        .cmd_kind_in(cmd_kind_in), .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
        .cmd_ready_out(cmd_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out));
    lait_device lait_device_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .bus(bus_if),
        .light_count_in(light_count_in), .conv_tick_out(conv_tick_out), .array_sel_out(array_sel_out),
        .integrating_out(integrating_out), .result_pulse_out(result_pulse_out));
    lait_checker lait_checker_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .req_valid(bus_if.req_valid),
        .req_kind(bus_if.req_kind), .req_addr(bus_if.req_addr), .req_wdata(bus_if.req_wdata),
        .rsp_valid(bus_if.rsp_valid), .rsp_rdata(bus_if.rsp_rdata), .conv_tick_out(conv_tick_out),
        .integrating_out(integrating_out), .result_pulse_out(result_pulse_out));
    initial forever #2 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic req(input lait_req_t k, input logic [7:0] a, input logic [7:0] d);
        int t = 0;
        while (cmd_ready_out !== 1'b1 && t < 100) begin step(1); t++; end
        if (cmd_ready_out !== 1'b1) n_mismatch++;
        cmd_valid_in = 1'b1;
        cmd_kind_in  = k;
        cmd_addr_in  = a;
        cmd_wdata_in = d;
        step(1);
        cmd_valid_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int t = 0;
        req(LAIT_REQ_READ, a, 8'h00);
        while (rd_valid_out !== 1'b1 && t < 10) begin step(1); t++; end
        if (rd_valid_out !== 1'b1) n_mismatch++;
        v = rd_data_out;
    endtask
    task automatic wait_res(input int n);
        int t  = 0;
        int tg = n_res + n;
        while (n_res < tg && t < 70000) begin step(1); t++; end
        if (n_res < tg) n_mismatch++;
    endtask
    ////////////////////////////////////////
    // Period monitor; the cycle ceiling sits last since the verdict ends the run
    always @(posedge clk_sys_in) begin
        cyc++;
        cyc_cnt++;
        if (result_pulse_out === 1'b1) begin
            per_cyc  = cyc_cnt;
            per_tick = tick_cnt;
            cyc_cnt  = 0;
            tick_cnt = 0;
            // Model: each result carries the light input that stood at its capture
            lc_q.push_back(int'(light_count_in));
            n_res++;
        end
        if (conv_tick_out === 1'b1) tick_cnt++;
        if (cyc == 90000) begin n_mismatch++; print_verdict(); end
    end
    ////////////////////////////////////////
    initial begin
        logic [7:0]  v, hi;
        int          wd [6] = '{3, 3, 3, 3, 2, 1};
        int          rg [6];
        int          n, e, tv;
        void'($urandom(17));
        step(20);
        sys_rst_in = 1'b0;
        rd(LAIT_OFS_COMMAND, v); check(32'(v), 32'(LAIT_RST_COMMAND));
        rd(LAIT_OFS_CONTROL, v); check(32'(v), 32'(LAIT_RST_CONTROL));
        rd(8'h02, v); check(32'(v), 32'h0);
        rg = '{0, 1, 2, 3, $urandom % 4, 2};
        // Range changes go in without reset; the third pulse bounds a clean period
        for (int i = 0; i < 6; i++) begin
            light_count_in = 16'($urandom);
            req(LAIT_REQ_WRITE, LAIT_OFS_CONTROL, 8'(rg[i] << LAIT_BIT_RANGE_LO));
            req(LAIT_REQ_WRITE, LAIT_OFS_COMMAND, 8'(wd[i]));
            rd(LAIT_OFS_COMMAND, v); check(32'(v), 32'(wd[i]));
            wait_res(3);
            e = 1 << (16 - 4 * wd[i]);
            check(32'(per_tick), 32'(e));
            check(32'(per_cyc), 32'(e * (rg[i] >= 2 ? LAIT_FAST_DIV : LAIT_SLOW_DIV)));
            rd(LAIT_OFS_DATA_LSB, v); check(32'(v), lc_q[$] & 32'hff);
            rd(LAIT_OFS_DATA_MSB, v); check(32'(v), (lc_q[$] >> 8) & 32'hff);
        end
        req(LAIT_REQ_WRITE, LAIT_OFS_CONTROL, 8'h08);
        req(LAIT_REQ_WRITE, LAIT_OFS_COMMAND, 8'h20);
        step(4);
        check(32'(integrating_out), 32'h0);
        // Short equal spacing keeps the count far below the counter limit
        n = 40 + $urandom % 60;
        light_count_in = 16'($urandom);
        req(LAIT_REQ_SYNC, 8'h00, 8'h00);
        step(3);
        check(32'(integrating_out), 32'h1);
        check(32'(array_sel_out), 32'h0);
        step(n);
        req(LAIT_REQ_SYNC, 8'h00, 8'h00);
        step(3);
        check(32'(array_sel_out), 32'h1);
        step(n);
        req(LAIT_REQ_SYNC, 8'h00, 8'h00);
        wait_res(1);
        check(32'(array_sel_out), 32'h0);
        check(32'(integrating_out), 32'h1);
        rd(LAIT_OFS_TIMER_LSB, v);
        rd(LAIT_OFS_TIMER_MSB, hi);
        tv = {hi, v};
        e = (2 * n + 8) / LAIT_FAST_DIV;
        check({31'h0, (tv >= e - 2 && tv <= e + 2)}, 32'h1);
        rd(LAIT_OFS_DATA_LSB, v); check(32'(v), 32'(light_count_in[7:0]));
        print_verdict();
    end
endmodule
